// *** hw/nvpe_array.sv ***
// 256 x 8 nonvolatile array model with registered read data
`timescale 1ns/100ps
`default_nettype none
module nvpe_array (
    input wire logic clk,
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_reg [0:255];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_reg[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem_reg[raddr];
    end
endmodule // nvpe_array
`default_nettype wire

// *** hw/nvpe_cfg.svh ***
// Constants for the byte program/erase control block
`ifndef NVPE_CFG_SVH
`define NVPE_CFG_SVH
`define NVPE_CTRL_ADDR 16'h0007
`define NVPE_ARRAY_BASE 16'h0100
`define NVPE_ARRAY_LAST 16'h01FF
`define NVPE_OPTION_ADDR 16'h0100
`define NVPE_CTRL_RESET 8'h00
`define NVPE_BIT_PUMP 0
`define NVPE_BIT_LATCH 1
`define NVPE_BIT_ERASE 2
`define NVPE_BIT_CLKOUT 3
`define NVPE_ERASED_BYTE 8'hFF
`define NVPE_PROGRAMMED_BYTE 8'h00
`define NVPE_BLOCKED_READ 8'hFF
`endif

// *** hw/nvpe_ctrl.sv ***
// Byte program/erase controller for the 256-byte nonvolatile array
// Operation
// - 256 bytes at 0x0100-0x01FF, byte erasable
// - 255 general bytes, one option byte
// - No bulk or row erase
// - Erase select picks erase or program
// - Erase select frozen after address capture
// - Latch without pump captures address only
// - Latch low: readable, erase/pump forced zero
// - Stop or reset clears latch enable
// - Pump bit drives charge pump high voltage
// - Pump refused until address captured
// - Pump cleared only by clearing latch
// - Latch, pump and capture flags decode the four states
// - Latch-low combinations behave as read; pump without capture as pumping
// - Register resets zero, upper nibble zero
// - Array reads all ones while latched
// - New address ignored until latch cleared
// - Erased reads FF, programmed reads 00
`timescale 1ns/100ps
`default_nettype none
`include "nvpe_cfg.svh"
module nvpe_ctrl
    import nvpe_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stop_mode,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic array_sel,
    output logic pump_voltage_pin,
    output logic bus_clock_output_enable,
    output logic [1:0] ctrl_state
);
    logic erase_select_reg;
    logic latch_enable_reg;
    logic pump_enable_reg;
    logic clkout_reg;
    logic captured_reg;
    logic [7:0] cap_addr_reg;
    logic blocked_reg;
    logic ctrl_read_reg;
    logic [7:0] ctrl_rdata_reg;
    logic pump_fall;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic ctrl_hit;
    logic array_hit;
    logic latch_next;
    nvpe_state_type state_next;

    assign ctrl_hit = (bus_addr == `NVPE_CTRL_ADDR);
    assign array_hit = (bus_addr >= `NVPE_ARRAY_BASE) && (bus_addr <= `NVPE_ARRAY_LAST);
    assign array_sel = array_hit;
    assign latch_next = bus_wdata[`NVPE_BIT_LATCH];

    // Latch enable: cleared by stop and reset
    always_ff @(posedge clk) begin
        if (!rst_b || stop_mode) begin
            latch_enable_reg <= 1'b0;
        end else if (bus_wr && ctrl_hit) begin
            latch_enable_reg <= latch_next;
        end
    end

    // Erase select frozen once an address is held; forced low without latch
    always_ff @(posedge clk) begin
        if (!rst_b || stop_mode) begin
            erase_select_reg <= 1'b0;
        end else if (bus_wr && ctrl_hit) begin
            if (!latch_next) begin
                erase_select_reg <= 1'b0;
            end else if (!captured_reg) begin
                erase_select_reg <= bus_wdata[`NVPE_BIT_ERASE];
            end
        end
    end

    // Pump bit: set only after capture, cleared only with latch
    always_ff @(posedge clk) begin
        if (!rst_b || stop_mode) begin
            pump_enable_reg <= 1'b0;
        end else if (bus_wr && ctrl_hit) begin
            if (!latch_next) begin
                pump_enable_reg <= 1'b0;
            end else if (bus_wdata[`NVPE_BIT_PUMP] && captured_reg && latch_enable_reg) begin
                pump_enable_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clkout_reg <= 1'b0;
        end else if (bus_wr && ctrl_hit) begin
            clkout_reg <= bus_wdata[`NVPE_BIT_CLKOUT];
        end
    end

    // First array write after latching holds the target address
    always_ff @(posedge clk) begin
        if (!rst_b || stop_mode) begin
            captured_reg <= 1'b0;
            cap_addr_reg <= 8'h00;
        end else if (bus_wr && ctrl_hit && !latch_next) begin
            captured_reg <= 1'b0;
        end else if (bus_wr && array_hit && latch_enable_reg && !pump_enable_reg
                     && !captured_reg) begin
            captured_reg <= 1'b1;
            cap_addr_reg <= bus_addr[7:0];
        end
    end

    // Commit one byte when a latch-clearing control write stops the pump, also in stop mode; stop alone commits nothing; data ignored, erase FF, program 00
    assign pump_fall = pump_enable_reg && bus_wr && ctrl_hit && !latch_next;
    assign mem_we = pump_fall && captured_reg;
    assign mem_wdata = erase_select_reg ? `NVPE_ERASED_BYTE : `NVPE_PROGRAMMED_BYTE;

    nvpe_array u_array (
        .clk(clk),
        .we(mem_we),
        .waddr(cap_addr_reg),
        .wdata(mem_wdata),
        .raddr(bus_addr[7:0]),
        .rdata(mem_rdata)
    );

    // Read path registers follow the memory's one-cycle latency
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            blocked_reg <= 1'b0;
            ctrl_read_reg <= 1'b0;
            ctrl_rdata_reg <= `NVPE_CTRL_RESET;
        end else begin
            blocked_reg <= latch_enable_reg;
            ctrl_read_reg <= bus_rd && ctrl_hit;
            ctrl_rdata_reg <= {4'h0, clkout_reg, erase_select_reg, latch_enable_reg,
                               pump_enable_reg};
        end
    end

    always_comb begin
        if (ctrl_read_reg) begin
            bus_rdata = ctrl_rdata_reg;
        end else if (blocked_reg) begin
            bus_rdata = `NVPE_BLOCKED_READ;
        end else begin
            bus_rdata = mem_rdata;
        end
    end

    // State decode; latch-low combinations fall back to read, pump without capture decodes as pumping
    always_comb begin
        if (!latch_enable_reg) begin
            state_next = NVPE_READ;
        end else if (pump_enable_reg) begin
            state_next = NVPE_PUMPING;
        end else if (captured_reg) begin
            state_next = NVPE_CAPTURED;
        end else begin
            state_next = NVPE_ARMED;
        end
    end

    assign ctrl_state = state_next;
    assign pump_voltage_pin = pump_enable_reg;
    assign bus_clock_output_enable = clkout_reg;
endmodule // nvpe_ctrl
`default_nettype wire

// *** hw/nvpe_pkg.sv ***
// Types for the byte program/erase control block
package nvpe_pkg;
    typedef enum logic [1:0] {
        NVPE_READ,
        NVPE_ARMED,
        NVPE_CAPTURED,
        NVPE_PUMPING
    } nvpe_state_type;
endpackage

// *** verification/nvpe_cpu.sv ***
// CPU bus master model
`timescale 1ns/100ps
`default_nettype none
module nvpe_cpu (
    input wire logic clk,
    output logic [15:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic [7:0] bus_wdata
);
    initial {bus_addr, bus_wr, bus_rd, bus_wdata} = '0;
    task automatic cyc(input logic [15:0] a, input logic w, r, input logic [7:0] d);
        bus_addr = a;
        bus_wr = w;
        bus_rd = r;
        bus_wdata = d;
        @(posedge clk);
        #1;
    endtask
endmodule // nvpe_cpu
`default_nettype wire

// *** verification/nvpe_ctrl_asserts.sv ***
// Port checker for the program/erase controller
`timescale 1ns/100ps
`default_nettype none
module nvpe_ctrl_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stop_mode,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic array_sel,
    input wire logic pump_voltage_pin,
    input wire logic bus_clock_output_enable,
    input wire logic [1:0] ctrl_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_cw;
        bus_wr && bus_addr == 16'h0007 && !stop_mode;
    endsequence
    sequence s_aw;
        bus_wr && array_sel && !stop_mode;
    endsequence
    a_arm_latch: assert property (s_cw ##0 ctrl_state == 2'h0 && bus_wdata[1] |=> ctrl_state == 2'h1)
        else $error("arm");
    a_capture_first: assert property (s_aw ##0 ctrl_state == 2'h1 |=> ctrl_state == 2'h2)
        else $error("capture");
    a_addr_held: assert property (s_aw ##0 ctrl_state[1] |=> $stable(ctrl_state))
        else $error("held");
    a_pump_rise: assert property ($rose(pump_voltage_pin) |-> $past(ctrl_state) == 2'h2)
        else $error("rise");
    a_pump_keep: assert property (s_cw ##0 pump_voltage_pin && bus_wdata[1] |=> pump_voltage_pin)
        else $error("keep");
    a_latch_off: assert property (s_cw ##0 !bus_wdata[1] |=> ctrl_state == 2'h0 && !pump_voltage_pin)
        else $error("off");
    a_stop_clear: assert property (stop_mode |=> ctrl_state == 2'h0 && !pump_voltage_pin)
        else $error("stop");
    a_latched_ones: assert property (bus_rd && array_sel && ctrl_state != 2'h0 |=> bus_rdata == 8'hFF)
        else $error("ones");
    a_clkout_write: assert property (s_cw |=> bus_clock_output_enable == $past(bus_wdata[3]))
        else $error("clock output bit");
endmodule // nvpe_ctrl_asserts
bind nvpe_ctrl nvpe_ctrl_asserts u_chk (.clk(clk), .rst_b(rst_b), .stop_mode(stop_mode),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .array_sel(array_sel), .pump_voltage_pin(pump_voltage_pin),
    .bus_clock_output_enable(bus_clock_output_enable), .ctrl_state(ctrl_state));
`default_nettype wire

// *** verification/nvpe_ctrl_bench.sv ***
// Self-checking bench for the program/erase controller
`timescale 1ns/100ps
`default_nettype none
module nvpe_ctrl_bench;
    logic clk = 1'b0, rst_b = 1'b0, stop_mode = 1'b0, rd_d = 1'b0;
    logic [15:0] bus_addr, a;
    logic bus_wr, bus_rd, array_sel, pump_voltage_pin, bus_clock_output_enable;
    logic [7:0] bus_wdata, bus_rdata, q[$];
    logic [1:0] ctrl_state;
    logic [31:0] seed = 32'h1B81A429;
    int miscompares = 0, checks_done = 0;
    always #20 clk = ~clk;
    nvpe_cpu cpu (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata));
    nvpe_ctrl uut (.clk(clk), .rst_b(rst_b), .stop_mode(stop_mode), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .array_sel(array_sel), .pump_voltage_pin(pump_voltage_pin),
        .bus_clock_output_enable(bus_clock_output_enable), .ctrl_state(ctrl_state));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        cpu.cyc(ad, 1'b1, 1'b0, d);
    endtask
    task automatic chk(input logic [15:0] ad, input logic [7:0] e);
        q.push_back(e);
        cpu.cyc(ad, 1'b0, 1'b1, 8'h00);
    endtask
    task automatic idle(input int n);
        repeat (n) cpu.cyc(~bus_addr, 1'b0, 1'b0, ~bus_wdata);
    endtask
    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR bus_rdata expected %h seen %h", e, g);
        end
    endtask
    // Read data stands between the edge after the request and the next edge
    always @(posedge clk) begin
        rd_d <= bus_rd;
    end
    always @(negedge clk) begin
        if (rd_d) cmp(q.pop_front(), bus_rdata);
    end
    task automatic conclude;
        if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        conclude;
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        chk(16'h0007, 8'h00);
        wr(16'h0007, 8'hFD);
        chk(16'h0007, 8'h08);
        wr(16'h0007, 8'h0B);
        chk(16'h0007, 8'h0A);
        stop_mode = 1'b1;
        idle(1);
        stop_mode = 1'b0;
        chk(16'h0007, 8'h08);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            a = {8'h01, seed[7:0]};
            wr(16'h0007, {5'h00, i[0], 2'b10});
            wr(a, seed[15:8]);
            chk(a, 8'hFF);
            wr(a ^ 16'h0001, seed[23:16]);
            wr(16'h0007, {5'h00, ~i[0], 2'b11});
            chk(16'h0007, {5'h00, i[0], 2'b11});
            wr(16'h0007, 8'h06);
            chk(16'h0007, {5'h00, i[0], 2'b11});
            idle(20);
            wr(16'h0007, 8'h00);
            chk(a, i[0] ? 8'hFF : 8'h00);
            chk(16'h0007, 8'h00);
        end
        wr(16'h0007, 8'h0A);
        rst_b = 1'b0;
        idle(1);
        rst_b = 1'b1;
        chk(16'h0007, 8'h00);
        idle(2);
        conclude;
    end
endmodule // nvpe_ctrl_bench
`default_nettype wire
